/* src/binary_output_module.sv */
`timescale 1ns/1ps
`default_nettype none
module binary_output_module
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic flow_sample,
	input wire logic [volume_pulse_pkg::RATE_W-1:0] flow_ml,
	input wire logic [volume_pulse_pkg::CHANNELS*2-1:0] func,
	input wire logic [volume_pulse_pkg::CHANNELS-1:0] invert,
	input wire logic [volume_pulse_pkg::CHANNELS*volume_pulse_pkg::VOL_W-1:0] vol_per_pulse,
	input wire logic [volume_pulse_pkg::CHANNELS*volume_pulse_pkg::TIME_W-1:0] pulse_len,
	input wire logic [volume_pulse_pkg::CHANNELS*volume_pulse_pkg::TIME_W-1:0] gap_len,
	input wire logic [volume_pulse_pkg::CHANNELS-1:0] overflow_clear,
	output logic [volume_pulse_pkg::CHANNELS-1:0] out_closed,
	output logic [volume_pulse_pkg::CHANNELS-1:0] pulse_active,
	output logic [volume_pulse_pkg::CHANNELS*volume_pulse_pkg::PEND_W-1:0] pending,
	output logic [volume_pulse_pkg::CHANNELS-1:0] overflow
);
	import volume_pulse_pkg::*;

	// flow_ml is the volume in ml passed since the last sample strobe
	genvar i;
	generate
		for (i = 0; i < CHANNELS; i++) begin : g_ch
			pulse_channel u_ch (
				.clk(clk),
				.rst_n(rst_n),
				.ce(ce),
				.sample(flow_sample),
				.func(func[i*2 +: 2]),
				.invert(invert[i]),
				.rate_ml(flow_ml),
				.vol_per_pulse(vol_per_pulse[i*VOL_W +: VOL_W]),
				.pulse_len(pulse_len[i*TIME_W +: TIME_W]),
				.gap_len(gap_len[i*TIME_W +: TIME_W]),
				.overflow_clear(overflow_clear[i]),
				.out_closed(out_closed[i]),
				.pulse_active(pulse_active[i]),
				.pending(pending[i*PEND_W +: PEND_W]),
				.overflow(overflow[i])
			);
		end
	endgenerate
endmodule : binary_output_module
`default_nettype wire

/* src/pulse_channel.sv */
`timescale 1ns/1ps
`default_nettype none
module pulse_channel
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic sample,
	input wire logic [1:0] func,
	input wire logic invert,
	input wire logic [volume_pulse_pkg::RATE_W-1:0] rate_ml,
	input wire logic [volume_pulse_pkg::VOL_W-1:0] vol_per_pulse,
	input wire logic [volume_pulse_pkg::TIME_W-1:0] pulse_len,
	input wire logic [volume_pulse_pkg::TIME_W-1:0] gap_len,
	input wire logic overflow_clear,
	output logic out_closed,
	output logic pulse_active,
	output logic [volume_pulse_pkg::PEND_W-1:0] pending,
	output logic overflow
);
	import volume_pulse_pkg::*;

	pulse_state_e state_reg;
	logic [STEP_CW-1:0] step_reg;
	logic step_done;
	logic [ACC_W-1:0] acc_reg;
	logic [ACC_W-1:0] acc_sum;
	logic [TIME_W-1:0] time_reg;
	logic [PEND_W-1:0] pend_reg;
	logic [VOL_W-1:0] vol_eff;
	logic [TIME_W-1:0] plen_eff;
	logic [TIME_W-1:0] glen_eff;
	logic quantum;
	logic owed;
	logic start;
	logic take;
	logic pulse_mode;

	// zero settings are clamped to the smallest legal value
	assign vol_eff = (vol_per_pulse == '0) ? VOL_W'(1) : vol_per_pulse;
	assign plen_eff = (pulse_len == '0) ? TIME_MIN : pulse_len;
	assign glen_eff = (gap_len == '0) ? TIME_MIN : gap_len;
	assign pulse_mode = (func == FUNC_PULSE);
	assign acc_sum = acc_reg + ACC_W'(rate_ml);
	assign quantum = pulse_mode && sample && (acc_sum >= ACC_W'(vol_eff));
	// a gap runs its full length and chains straight into a pulse only with a pulse owed; idle starts on the quantum itself
	assign take = (state_reg == ST_GAP) && step_done && (time_reg <= TIME_MIN) && (pend_reg != '0);
	assign start = (state_reg == ST_IDLE) && (quantum || pend_reg != '0);
	assign owed = quantum && !(start && pend_reg == '0);

	// own 10 ms base per channel: a shared tick would cut the first step short
	assign step_done = (step_reg == STEP_CW'(STEP_CYCLES - 1));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			step_reg <= '0;
		end else if (ce) begin
			if (state_reg == ST_IDLE || step_done) begin
				step_reg <= '0;
			end else begin
				step_reg <= step_reg + 20'h00001;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_reg <= '0;
		end else if (ce) begin
			if (!pulse_mode) begin
				acc_reg <= '0;
			end else if (quantum) begin
				acc_reg <= acc_sum - ACC_W'(vol_eff);
			end else if (sample) begin
				acc_reg <= acc_sum;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			time_reg <= '0;
		end else if (ce) begin
			case (state_reg)
				ST_IDLE: begin
					if (start) begin
						state_reg <= ST_PULSE;
						time_reg <= plen_eff;
					end
				end
				ST_PULSE: begin
					if (!pulse_mode) begin
						state_reg <= ST_IDLE;
					end else if (step_done) begin
						if (time_reg <= TIME_MIN) begin
							state_reg <= ST_GAP;
							time_reg <= glen_eff;
						end else begin
							time_reg <= time_reg - TIME_MIN;
						end
					end
				end
				ST_GAP: begin
					if (!pulse_mode) begin
						state_reg <= ST_IDLE;
					end else if (take) begin
						state_reg <= ST_PULSE;
						time_reg <= plen_eff;
					end else if (step_done) begin
						if (time_reg <= TIME_MIN) begin
							state_reg <= ST_IDLE;
						end else begin
							time_reg <= time_reg - TIME_MIN;
						end
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// counter holds pulses owed while a pulse cycle runs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_reg <= PEND_RESET;
		end else if (ce) begin
			if (!pulse_mode) begin
				pend_reg <= PEND_RESET;
			end else begin
				case ({owed && pend_reg != PEND_MAX, (take || (start && pend_reg != '0))})
					2'b10: pend_reg <= pend_reg + 8'h01;
					2'b01: pend_reg <= pend_reg - 8'h01;
					default: pend_reg <= pend_reg;
				endcase
			end
		end
	end

	// sticky; a new overflow wins over a clear in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			overflow <= 1'b0;
		end else if (ce) begin
			if (owed && pend_reg == PEND_MAX && !(take || start)) begin
				overflow <= 1'b1;
			end else if (overflow_clear) begin
				overflow <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_closed <= 1'b0;
		end else if (ce) begin
			case (func)
				FUNC_CLOSED: out_closed <= 1'b1;
				FUNC_OPEN: out_closed <= 1'b0;
				FUNC_PULSE: out_closed <= (state_reg == ST_PULSE) ^ invert;
				default: out_closed <= 1'b0;
			endcase
		end
	end

	assign pulse_active = (state_reg == ST_PULSE);
	assign pending = pend_reg;
endmodule : pulse_channel
`default_nettype wire

/* src/volume_pulse_pkg.sv */
package volume_pulse_pkg;
	localparam int unsigned CHANNELS = 4;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned STEP_MS = 10;
	localparam int unsigned STEP_CYCLES = CLK_HZ / 1000 * STEP_MS;
	localparam int unsigned STEP_CW = 20;
	localparam int unsigned TIME_W = 8;
	localparam int unsigned VOL_W = 30;
	localparam int unsigned RATE_W = 24;
	localparam int unsigned ACC_W = 32;
	localparam int unsigned PEND_W = 8;
	localparam logic [PEND_W-1:0] PEND_MAX = 8'hFF;
	localparam logic [PEND_W-1:0] PEND_RESET = 8'h00;
	localparam logic [TIME_W-1:0] TIME_MIN = 8'h01;

	typedef enum logic [1:0] {
		FUNC_OPEN = 2'b00,
		FUNC_CLOSED = 2'b01,
		FUNC_PULSE = 2'b10
	} out_func_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PULSE = 2'b01,
		ST_GAP = 2'b10
	} pulse_state_e;
endpackage : volume_pulse_pkg

/* verif/binary_output_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module binary_output_asserts
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic flow_sample,
	input wire logic [volume_pulse_pkg::CHANNELS*2-1:0] func,
	input wire logic [volume_pulse_pkg::CHANNELS-1:0] invert,
	input wire logic [volume_pulse_pkg::CHANNELS-1:0] overflow_clear,
	input wire logic [volume_pulse_pkg::CHANNELS-1:0] out_closed,
	input wire logic [volume_pulse_pkg::CHANNELS-1:0] pulse_active,
	input wire logic [volume_pulse_pkg::CHANNELS*volume_pulse_pkg::PEND_W-1:0] pending,
	input wire logic [volume_pulse_pkg::CHANNELS-1:0] overflow
);
	import volume_pulse_pkg::*;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// channel 0 only, the others are copies
	sequence s_svc(logic [1:0] f);
		$past(rst_n) && $past(ce) && $past(func[1:0]) == f;
	endsequence
	sequence s_held;
		$past(pulse_active[0]) && pulse_active[0] && $past(ce);
	endsequence
	AST_SVC_CLOSED: assert property (s_svc(2'h1) |-> out_closed[0]) else $error("closed lost");
	AST_SVC_OPEN: assert property (s_svc(2'h0) |-> !out_closed[0]) else $error("open lost");
	AST_POLARITY: assert property (s_held |-> out_closed[0] == !$past(invert[0])) else $error("polarity");
	AST_START: assert property ($rose(pulse_active[0]) |-> $past(flow_sample)
		|| pending[7:0] == $past(pending[7:0]) - 8'h01) else $error("start");
	AST_PEND_STEP: assert property (pending[7:0] > $past(pending[7:0]) |-> $past(flow_sample)
		&& pending[7:0] == $past(pending[7:0]) + 8'h01) else $error("pending step");
	AST_OVF_SET: assert property ($rose(overflow[0]) |-> $past(flow_sample)
		&& $past(pending[7:0]) == PEND_MAX) else $error("overflow early");
	AST_OVF_HOLD: assert property (overflow[0] && !overflow_clear[0] |=> overflow[0]) else $error("sticky");
	AST_OVF_CLR: assert property (ce && overflow_clear[0] && !flow_sample |=> !overflow[0]) else $error("clear");
endmodule : binary_output_asserts
bind binary_output_module binary_output_asserts chk(.*);
`default_nettype wire

/* verif/binary_output_module_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module binary_output_module_tb;
	import volume_pulse_pkg::*;
	logic clk = 0, rst_n = 0, fs = 0, e, last = 0, ce = 1;
	logic [RATE_W-1:0] flow = '0;
	logic [7:0] func = '0;
	logic [3:0] inv = '0, oc = '0, cl, pa, ov;
	logic [119:0] vol = '0;
	logic [31:0] pend;
	int miscompares, n_tests, edges, cnt, acc[4], pq[4], busy[4], ovf[4];
	always #5 clk = ~clk;
	// pulses never end here: the first 10 ms step lies far beyond this run
	binary_output_module dut(.clk(clk), .rst_n(rst_n), .ce(ce), .flow_sample(fs), .flow_ml(flow),
		.func(func), .invert(inv), .vol_per_pulse(vol), .pulse_len(32'h0101_0101), .gap_len(32'h0101_0101),
		.overflow_clear(oc), .out_closed(cl), .pulse_active(pa), .pending(pend), .overflow(ov));
	pulse_counter peer(.rst_n(rst_n), .line(cl[0]), .count(cnt));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic compare();
		repeat (2) @(negedge clk);
		for (int c = 0; c < 4; c++) begin
			e = func[2*c+:2] == 2'h1 || (func[2*c+:2] == 2'h2 && (busy[c] ^ inv[c]));
			check(cl[c], e);
			check(pa[c], busy[c]);
			check(pend[8*c+:8], pq[c]);
			check(ov[c], ovf[c]);
			if (c == 0 && e && !last) edges++;
			if (c == 0) last = e;
		end
		check(cnt, edges);
	endtask : compare
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude
	initial begin
		#200us;
		miscompares++;
		conclude();
	end
	initial begin
		void'($urandom(97));
		repeat (20) @(posedge clk);
		@(negedge clk) rst_n = 1;
		for (int ph = 0; ph < 6; ph++) begin
			for (int c = 0; c < 4; c++) begin
				func[2*c+:2] = c == 0 ? (ph < 2 ? 2'(1 - ph) : 2'h2) : 2'($urandom % 4);
				inv[c] = c == 0 ? ph[0] : 1'($urandom);
				vol[30*c+:30] = 30'(1 + $urandom % 4);
				ovf[c] = 0;
				if (func[2*c+:2] != 2'h2) begin
					acc[c] = 0;
					pq[c] = 0;
					busy[c] = 0;
				end
			end
			oc = 4'hF;
			@(negedge clk) oc = 4'h0;
			compare();
			for (int i = 0; i < 100; i++) begin
				flow = RATE_W'($urandom % 16);
				fs = 1;
				ce = ($urandom % 8) != 0;
				// a sample under a low enable must be lost
				for (int c = 0; c < 4 && ce; c++) begin
					acc[c] += func[2*c+:2] == 2'h2 ? flow : 0;
					if (func[2*c+:2] == 2'h2 && acc[c] >= vol[30*c+:30]) begin
						acc[c] -= vol[30*c+:30];
						if (!busy[c]) busy[c] = 1;
						else if (pq[c] < 255) pq[c]++;
						else ovf[c] = 1;
					end
				end
				@(negedge clk);
				fs = 0;
				ce = 1'b1;
				compare();
			end
		end
		conclude();
	end
endmodule : binary_output_module_tb
`default_nettype wire

/* verif/pulse_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module pulse_counter (
	input wire logic rst_n,
	input wire logic line,
	output int count
);
	// a counter input sees closures only, never their length
	always_ff @(posedge line or negedge rst_n) begin
		if (!rst_n)
			count <= 0;
		else
			count <= count + 1;
	end
endmodule : pulse_counter
`default_nettype wire
